// [hw/iopd_top.v]
// I/O power-down controller: index/data configuration registers and the
// per-function and full-chip power, clock, pin and input controls.
// Assumes a host on the same clock driving one-cycle strobes, straps on
// asynchronous pins, and functions that keep their own register contents.
//
// Functional notes
// - Disabled function is powered down; its internal registers keep their contents.
// - Each function's output pins can be made high impedance by configuration.
// - Clocked functions save power by internal clock gating or stopping the crystal.
// - Floppy, both UARTs and ECP-mode parallel port are the clock-gated functions.
// - Standard/EPP parallel port and IDE power down by blocking all access.
// - Four full-chip modes: crystal running or stopped, pins floating or driven.
// - Mode 1: crystal stopped, all pins floating, all inputs blocked.
// - Mode 2: whole chip down, crystal stopped, output pins still driven.
// - Mode 3: pins floating, inputs blocked, crystal kept running for fast wake.
// - Mode 4: whole chip down, crystal running, output pins still driven.
// - Eight per-function modes combine power-down, pin float and input block.
// - Host reaches registers through an index port and a data port.
// - Function-enable and parallel ECP-mode defaults come from strap pins captured around reset release.
//
// The placing of the registers and the strobed register port were decided locally.
`include "iopd_defines.vh"

module iopd_top #(
  parameter OSC_START_CYC = `IOPD_OSC_START_CYC,
  parameter OSC_CNT_W = 18,
  parameter [7:0] ID_VALUE = `IOPD_ID_VALUE // Arbitrary value
) (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire [`IOPD_STRAP_W-1:0] strap_in,
  input wire reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  output reg osc_en_out,
  output reg [`IOPD_NUM_FN-1:0] fn_power_out,
  output reg [`IOPD_NUM_FN-1:0] fn_clk_en_out,
  output reg [`IOPD_NUM_FN-1:0] fn_access_en_out,
  output reg [`IOPD_NUM_FN-1:0] fn_pin_oe_en_out,
  output reg [`IOPD_NUM_FN-1:0] fn_input_en_out
);

  localparam NF = `IOPD_NUM_FN;

  // Configuration state
  reg [2:0] index_r;
  reg [NF-1:0] func_en_r;
  reg [NF-1:0] pin_hiz_r;
  reg [NF-1:0] in_block_r;
  reg [NF-1:0] clk_gate_r;
  reg [2:0] full_pd_r;
  reg par_ecp_r;
  reg [1:0] strap_cnt_r;
  reg strap_done_r;
  reg [7:0] rdata_nxt;

  wire [`IOPD_STRAP_W-1:0] strap_sync;
  wire osc_ready;
  wire data_wr;
  wire data_rd;
  wire full_any;
  wire full_osc_stop;
  wire full_hiz;
  wire osc_en_nxt;
  wire [NF-1:0] clocked;
  wire [NF-1:0] power_nxt;
  wire [NF-1:0] clk_en_nxt;
  wire [NF-1:0] access_nxt;
  wire [NF-1:0] oe_en_nxt;
  wire [NF-1:0] in_en_nxt;

  iopd_sync #(
    .WIDTH(`IOPD_STRAP_W)
  ) u_strap_sync (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .async_in(strap_in),
    .sync_out(strap_sync)
  );

  iopd_osc_timer #(
    .START_CYC(OSC_START_CYC),
    .CNT_W(OSC_CNT_W)
  ) u_osc_timer (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .osc_en_in(osc_en_out),
    .ready_out(osc_ready)
  );

  // Index port selects, data port moves the selected register
  assign data_wr = reg_wr_in && (reg_addr_in == `IOPD_ADDR_DATA);
  assign data_rd = reg_rd_in && (reg_addr_in == `IOPD_ADDR_DATA);

  // Strap capture: wait until the synchroniser holds post-reset pin values,
  // then load once. A host write in that same cycle loses to the strap.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == `IOPD_STRAP_LOAD_CYC - 2'h1) begin
        strap_done_r <= 1'b1;
      end else begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      index_r <= `IOPD_RST_INDEX;
      func_en_r <= `IOPD_RST_FUNC_EN;
      pin_hiz_r <= `IOPD_RST_ZERO5;
      in_block_r <= `IOPD_RST_ZERO5;
      clk_gate_r <= `IOPD_RST_ZERO5;
      full_pd_r <= `IOPD_RST_FULL_PD;
      par_ecp_r <= 1'b0;
    end else if (!strap_done_r && strap_cnt_r == `IOPD_STRAP_LOAD_CYC - 2'h1) begin
      func_en_r <= strap_sync[NF-1:0];
      par_ecp_r <= strap_sync[`IOPD_STRAP_ECP_BIT];
    end else if (reg_wr_in && reg_addr_in == `IOPD_ADDR_INDEX) begin
      index_r <= reg_wdata_in[2:0];
    end else if (data_wr) begin
      case (index_r)
        `IOPD_IDX_FUNC_EN: func_en_r <= reg_wdata_in[NF-1:0];
        `IOPD_IDX_PIN_HIZ: pin_hiz_r <= reg_wdata_in[NF-1:0];
        `IOPD_IDX_IN_BLOCK: in_block_r <= reg_wdata_in[NF-1:0];
        `IOPD_IDX_CLK_GATE: clk_gate_r <= reg_wdata_in[NF-1:0];
        `IOPD_IDX_FULL_PD: begin
          // Codes above mode 4 are ignored
          if (reg_wdata_in[2:0] <= `IOPD_FULL_MODE4) begin
            full_pd_r <= reg_wdata_in[2:0];
          end
        end
        `IOPD_IDX_PAR_MODE: par_ecp_r <= reg_wdata_in[`IOPD_PAR_ECP_BIT];
        default: begin
        end
      endcase
    end
  end

  // Full-chip mode decode
  assign full_any = (full_pd_r != `IOPD_FULL_NONE);
  assign full_osc_stop = (full_pd_r == `IOPD_FULL_MODE1) ||
                         (full_pd_r == `IOPD_FULL_MODE2);
  assign full_hiz = (full_pd_r == `IOPD_FULL_MODE1) ||
                    (full_pd_r == `IOPD_FULL_MODE3);
  assign osc_en_nxt = !full_osc_stop;

  // Clock-driven set: parallel port joins only in ECP mode
  assign clocked = {1'b0, par_ecp_r, 3'b111};

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi = gi + 1) begin : g_fn
      // Power removal only; the function keeps its data registers
      assign power_nxt[gi] = func_en_r[gi] && !full_any;
      // Clocks held off until the crystal is stable again
      assign clk_en_nxt[gi] = clocked[gi] && power_nxt[gi] && !clk_gate_r[gi] &&
                              osc_ready;
      // Non-clocked functions are powered down by refusing access
      assign access_nxt[gi] = power_nxt[gi] &&
                              (!clocked[gi] || osc_ready);
      assign oe_en_nxt[gi] = !pin_hiz_r[gi] && !full_hiz;
      assign in_en_nxt[gi] = !in_block_r[gi] && !full_hiz;
    end
  endgenerate

  always @* begin
    rdata_nxt = 8'h00;
    if (reg_rd_in && reg_addr_in == `IOPD_ADDR_INDEX) begin
      rdata_nxt = {5'h00, index_r};
    end else if (data_rd) begin
      case (index_r)
        `IOPD_IDX_FUNC_EN: rdata_nxt = {3'h0, func_en_r};
        `IOPD_IDX_PIN_HIZ: rdata_nxt = {3'h0, pin_hiz_r};
        `IOPD_IDX_IN_BLOCK: rdata_nxt = {3'h0, in_block_r};
        `IOPD_IDX_CLK_GATE: rdata_nxt = {3'h0, clk_gate_r};
        `IOPD_IDX_FULL_PD: rdata_nxt = {5'h00, full_pd_r};
        `IOPD_IDX_STATUS: rdata_nxt = {4'h0, strap_done_r, full_hiz, osc_en_out, osc_ready};
        `IOPD_IDX_PAR_MODE: rdata_nxt = {7'h00, par_ecp_r};
        `IOPD_IDX_ID: rdata_nxt = ID_VALUE;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // All outputs registered; read data stand for one cycle only
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
      osc_en_out <= 1'b1;
      fn_power_out <= {NF{1'b0}};
      fn_clk_en_out <= {NF{1'b0}};
      fn_access_en_out <= {NF{1'b0}};
      fn_pin_oe_en_out <= {NF{1'b0}};
      fn_input_en_out <= {NF{1'b0}};
    end else begin
      reg_rdata_out <= rdata_nxt;
      osc_en_out <= osc_en_nxt;
      fn_power_out <= power_nxt;
      fn_clk_en_out <= clk_en_nxt;
      fn_access_en_out <= access_nxt;
      fn_pin_oe_en_out <= oe_en_nxt;
      fn_input_en_out <= in_en_nxt;
    end
  end

endmodule // iopd_top

// [hw/iopd_defines.vh]
// Constants for the I/O power-down controller: port offsets, register
// indices, field positions, reset values and timing counts.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef IOPD_DEFINES_VH
`define IOPD_DEFINES_VH

// Register port addresses
`define IOPD_ADDR_INDEX 1'h0
`define IOPD_ADDR_DATA 1'h1

// Configuration register indices
`define IOPD_IDX_FUNC_EN 3'h0
`define IOPD_IDX_PIN_HIZ 3'h1
`define IOPD_IDX_IN_BLOCK 3'h2
`define IOPD_IDX_CLK_GATE 3'h3
`define IOPD_IDX_FULL_PD 3'h4
`define IOPD_IDX_STATUS 3'h5
`define IOPD_IDX_PAR_MODE 3'h6
`define IOPD_IDX_ID 3'h7

// Function bit positions inside the per-function registers
`define IOPD_FN_FDC 0
`define IOPD_FN_UART1 1
`define IOPD_FN_UART2 2
`define IOPD_FN_PAR 3
`define IOPD_FN_IDE 4
`define IOPD_NUM_FN 5

// Full-chip power-down mode codes
`define IOPD_FULL_NONE 3'h0
`define IOPD_FULL_MODE1 3'h1
`define IOPD_FULL_MODE2 3'h2
`define IOPD_FULL_MODE3 3'h3
`define IOPD_FULL_MODE4 3'h4

// Parallel port mode field
`define IOPD_PAR_ECP_BIT 0

// Strap field positions
`define IOPD_STRAP_ECP_BIT 5
`define IOPD_STRAP_W 8

// Reset values
`define IOPD_RST_FUNC_EN 5'h00
`define IOPD_RST_ZERO5 5'h00
`define IOPD_RST_FULL_PD 3'h0
`define IOPD_RST_INDEX 3'h0
`define IOPD_ID_VALUE 8'h5a

// Timing
`define IOPD_CLK_PERIOD_NS 5
`define IOPD_OSC_START_NS 1000000
`define IOPD_OSC_START_CYC (`IOPD_OSC_START_NS / `IOPD_CLK_PERIOD_NS)
`define IOPD_STRAP_LOAD_CYC 2'h3

`endif

// [hw/iopd_sync.v]
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the inputs are quasi-static levels; no event is carried.
module iopd_sync #(
  parameter WIDTH = 8
) (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_r <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // iopd_sync

// [hw/iopd_osc_timer.v]
// Crystal restart timer: reports ready once the oscillator has run
// for START_CYC cycles since it was last enabled.
// Assumes osc_en_in comes from a flop on the same clock.
module iopd_osc_timer #(
  parameter START_CYC = 200000,
  parameter CNT_W = 18
) (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire osc_en_in,
  output reg ready_out
);

  reg [CNT_W-1:0] cnt_r;

  // Counts from reset too: the crystal is assumed cold at power-on
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= {CNT_W{1'b0}};
      ready_out <= 1'b0;
    end else if (!osc_en_in) begin
      cnt_r <= {CNT_W{1'b0}};
      ready_out <= 1'b0;
    end else if (!ready_out) begin
      if (cnt_r == START_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) begin
        ready_out <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // iopd_osc_timer

// [testbench/iopd_top_props.sv]
// Checker on the ports of iopd_top.
// Assumes the bind below and OSC_START_CYC of at least 8.
module iopd_top_props #(
  parameter OSC_START_CYC = 8
) (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire osc_en_out,
  input wire [4:0] fn_power_out,
  input wire [4:0] fn_clk_en_out,
  input wire [4:0] fn_access_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  property p_rd_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_ide_noclk;
    fn_clk_en_out[4] == 1'b0;
  endproperty
  a_ide_noclk: assert property (p_ide_noclk) else $error("ide clock enabled");
  property p_clk_power;
    (fn_clk_en_out & ~fn_power_out) == 5'h00;
  endproperty
  a_clk_power: assert property (p_clk_power) else $error("clock on unpowered");
  property p_acc_power;
    (fn_access_en_out & ~fn_power_out) == 5'h00;
  endproperty
  a_acc_power: assert property (p_acc_power) else $error("access on unpowered");
  property p_osc_stop;
    $fell(osc_en_out) |-> ##2 fn_clk_en_out == 5'h00;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("clock kept after stop");
  property p_osc_wake;
    $rose(osc_en_out) |-> (fn_clk_en_out == 5'h00 && fn_access_en_out[2:0] == 3'h0) [*8];
  endproperty
  a_osc_wake: assert property (p_osc_wake) else $error("early wake");
  property p_osc_pd;
    $fell(osc_en_out) |-> fn_power_out == 5'h00;
  endproperty
  a_osc_pd: assert property (p_osc_pd) else $error("powered with osc stop");
  property p_osc_cause;
    $fell(osc_en_out) |-> $past(reg_wr_in, 2) && $past(reg_addr_in, 2);
  endproperty
  a_osc_cause: assert property (p_osc_cause) else $error("osc stop uncaused");
endmodule // iopd_top_props
bind iopd_top iopd_top_props #(.OSC_START_CYC(OSC_START_CYC)) u_props (
  .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .osc_en_out(osc_en_out), .fn_power_out(fn_power_out), .fn_clk_en_out(fn_clk_en_out),
  .fn_access_en_out(fn_access_en_out));

// [testbench/iopd_host_model.sv]
// Host model: index/data register access over one-cycle strobes.
// Assumes the caller waits for the first legal edge after reset.
module iopd_host_model (
  input wire clk_in,
  input wire [7:0] rdata_in,
  output logic addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out = 1'b0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Index write, then data access on the next cycle
  task wr_reg(input [2:0] idx, input [7:0] val);
    @(posedge clk_in);
    addr_out <= 1'b0;
    wdata_out <= {5'h00, idx};
    wr_out <= 1'b1;
    @(posedge clk_in);
    addr_out <= 1'b1;
    wdata_out <= val;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask
  task rd_reg(input [2:0] idx, output [7:0] val);
    @(posedge clk_in);
    addr_out <= 1'b0;
    wdata_out <= {5'h00, idx};
    wr_out <= 1'b1;
    @(posedge clk_in);
    addr_out <= 1'b1;
    wr_out <= 1'b0;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    // Read data stand only in the cycle after the strobe
    @(posedge clk_in);
    val = rdata_in;
  endtask
  // Readback of the index port itself
  task rd_index(output [7:0] val);
    @(posedge clk_in);
    addr_out <= 1'b0;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    val = rdata_in;
  endtask
endmodule // iopd_host_model

// [testbench/tb.sv]
// Self-checking bench for iopd_top with a short crystal restart.
// Assumes the host model and the bound checker are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC = 8;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0, reg_addr_in, reg_wr_in, reg_rd_in, ecp, osc_en_out;
  logic [7:0] strap_in = 8'h00, reg_wdata_in, reg_rdata_out, rv;
  logic [4:0] fn_power_out, fn_clk_en_out, fn_access_en_out, fn_pin_oe_en_out, fn_input_en_out;
  logic [4:0] en, hiz, blk, gate;
  integer seed = 33, bad_count = 0, checks_done = 0, i, m;
  iopd_top #(.OSC_START_CYC(OSC)) uut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .strap_in(strap_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .osc_en_out(osc_en_out), .fn_power_out(fn_power_out), .fn_clk_en_out(fn_clk_en_out),
    .fn_access_en_out(fn_access_en_out), .fn_pin_oe_en_out(fn_pin_oe_en_out),
    .fn_input_en_out(fn_input_en_out));
  iopd_host_model host (.clk_in(clk_sys_in), .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  function automatic [25:0] exp_out(input [2:0] fm, input rdy);
    logic [4:0] ck, pw;
    logic fh;
    ck = {1'b0, ecp, 3'b111};
    fh = (fm == 3'h1) || (fm == 3'h3);
    pw = en & {5{fm == 3'h0}};
    exp_out = {!(fm == 3'h1 || fm == 3'h2), pw, ck & pw & ~gate & {5{rdy}},
      pw & (~ck | {5{rdy}}), ~hiz & {5{!fh}}, ~blk & {5{!fh}}};
  endfunction
  task miss(input string msg);
    bad_count++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task chk_out(input [25:0] e);
    checks_done++;
    if ({osc_en_out, fn_power_out, fn_clk_en_out, fn_access_en_out, fn_pin_oe_en_out,
        fn_input_en_out} !== e) miss("control outputs differ");
  endtask
  task chk_rd(input [2:0] idx, input [7:0] e);
    host.rd_reg(idx, rv);
    checks_done++;
    if (rv !== e) miss("register read differs");
  endtask
  task chk_idx(input [7:0] e);
    host.rd_index(rv);
    checks_done++;
    if (rv !== e) miss("index readback differs");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task set_fn;
    host.wr_reg(3'h0, {3'h0, en});
    host.wr_reg(3'h1, {3'h0, hiz});
    host.wr_reg(3'h2, {3'h0, blk});
    host.wr_reg(3'h3, {3'h0, gate});
    host.wr_reg(3'h6, {7'h00, ecp});
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask
  initial begin
    #200000 miss("run too long");
    close_out;
  end
  initial begin
    rv = 8'($random(seed));
    {ecp, en} = rv[5:0];
    {hiz, blk, gate} = 15'h0000;
    @(posedge clk_sys_in);
    strap_in <= rv;
    repeat (5) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    // Straps land on the 3rd edge, clocks after the restart count
    repeat (OSC + 6) @(posedge clk_sys_in);
    #1 chk_out(exp_out(3'h0, 1'b1));
    chk_rd(3'h0, {3'h0, en});
    chk_rd(3'h5, 8'h0b);
    host.wr_reg(3'h7, 8'h00);
    chk_rd(3'h7, 8'h5a);
    chk_idx(8'h07);
    $display("test reset done");
    for (i = 0; i < 20; i++) begin
      {ecp, gate, blk, hiz, en} = 21'($random(seed));
      if (i == 0) {ecp, gate, blk, hiz, en} = 21'h00001f;
      set_fn;
      chk_out(exp_out(3'h0, 1'b1));
      chk_rd(3'h1, {3'h0, hiz});
    end
    $display("test per-function done");
    {ecp, gate, blk, hiz, en} = 21'h10001f;
    set_fn;
    for (m = 1; m <= 4; m++) begin
      host.wr_reg(3'h4, m[7:0]);
      repeat (4) @(posedge clk_sys_in);
      #1 chk_out(exp_out(m[2:0], m > 2));
      host.wr_reg(3'h4, 8'h05);
      chk_rd(3'h4, m[7:0]);
      host.wr_reg(3'h4, 8'h00);
      // Running crystal wakes at once; a stopped one holds clocks off
      @(posedge clk_sys_in);
      #1 chk_out(exp_out(3'h0, m > 2));
      repeat (OSC + 3) @(posedge clk_sys_in);
      #1 chk_out(exp_out(3'h0, 1'b1));
    end
    $display("test full modes done");
    close_out;
  end
endmodule // tb
